// ### inc/lane_sync_pkg.sv
// Package of constants and types for the lane sync status block
package lane_sync_pkg;

    // ==================================================================
    // Sizes
    localparam int LANES         = 4;
    localparam int ERR_CNT_W     = 3;
    localparam int MAP_W         = 2;
    localparam int PERIOD_W      = 16;

    // ==================================================================
    // Reset values
    localparam logic [LANES-1:0]    LANE_BITS_RST = 4'h0;
    localparam logic [ERR_CNT_W-1:0] ERR_CNT_RST  = 3'h0;
    localparam logic [MAP_W-1:0]    MAP_RST       = 2'h0;
    localparam logic [PERIOD_W-1:0] PERIOD_RST    = 16'h3FFF;

    // ==================================================================
    // Word-sync decisions
    localparam logic [5:0] SH_BAD_LIMIT = 6'h10;
    localparam logic [6:0] SH_WINDOW    = 7'h40;

    // ==================================================================
    // Per-lane sync states
    typedef enum logic [1:0] {
        ST_HUNT   = 2'b00,
        ST_LOCKED = 2'b01,
        ST_MARKED = 2'b10
    } sync_state_t;

endpackage

// ### rtl/lane_sync_unit.sv
// One lane of sync header checking and marker spacing tracking
`timescale 1ns/1ps
`default_nettype none
module lane_sync_unit
    import lane_sync_pkg::*;
#(
    parameter int PW = PERIOD_W
)
(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 clk_en,
    // Lane inputs, already synchronised, and the marker period setting, passed straight in
    input  wire logic                 word_valid,
    input  wire logic                 sh_error,
    input  wire logic                 marker_seen,
    input  wire logic [MAP_W-1:0]     phys_lane,
    input  wire logic [PW-1:0]        marker_period_setting,
    // Status
    output logic [ERR_CNT_W-1:0]      err_count,
    output logic                      err_count_valid,
    output logic                      block_lock,
    output logic                      marker_found,
    output logic                      word_synced,
    output logic                      sync_err,
    output logic                      spacing_err,
    output logic [MAP_W-1:0]          lane_map
);
    sync_state_t    state;
    sync_state_t    next_state;
    logic [6:0]     win_cnt;
    logic [5:0]     bad_cnt;
    logic [PW-1:0]  gap_cnt;
    logic           ever_marker;
    logic           lost_lock;
    logic           win_end;
    logic           gap_ok;

    assign win_end = word_valid && (win_cnt == SH_WINDOW - 7'h01);
    // Seven bits, so a window of all-bad headers cannot wrap to zero
    assign lost_lock = win_end
        && ({1'b0, bad_cnt} + {6'h00, sh_error} >= {1'b0, SH_BAD_LIMIT});
    assign gap_ok = (gap_cnt == marker_period_setting);

    // ==================================================================
    // Sync state
    always_comb
    begin
        next_state = state;
        case (state)
            ST_HUNT:   if (win_end && !lost_lock) next_state = ST_LOCKED;
            ST_LOCKED:
            begin
                if (lost_lock) next_state = ST_HUNT;
                else if (word_valid && marker_seen) next_state = ST_MARKED;
            end
            ST_MARKED: if (lost_lock) next_state = ST_HUNT;
            default:   next_state = ST_HUNT;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst) state <= ST_HUNT;
        else if (clk_en) state <= next_state;
    end

    // ==================================================================
    // Sync header error window
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            win_cnt <= 7'h00;
            bad_cnt <= 6'h00;
        end
        else if (clk_en && word_valid)
        begin
            win_cnt <= win_end ? 7'h00 : win_cnt + 7'h01;
            bad_cnt <= win_end ? 6'h00 : bad_cnt + {5'h00, sh_error};
        end
    end

    // ==================================================================
    // Per-cycle error increment, valid only with its strobe
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            err_count       <= ERR_CNT_RST;
            err_count_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            err_count_valid <= word_valid;
            err_count <= {2'h0, word_valid && sh_error};
        end
    end

    // ==================================================================
    // Marker spacing: markers must have exactly period non-marker words between them
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            gap_cnt     <= '0;
            ever_marker <= 1'b0;
            spacing_err <= 1'b0;
            lane_map    <= MAP_RST;
        end
        else if (clk_en)
        begin
            if (state == ST_HUNT)
            begin
                ever_marker <= 1'b0;
                spacing_err <= 1'b0;
                gap_cnt     <= '0;
            end
            else if (word_valid)
            begin
                if (marker_seen)
                begin
                    if (ever_marker) spacing_err <= !gap_ok;
                    ever_marker <= 1'b1;
                    gap_cnt     <= '0;
                    lane_map    <= phys_lane;
                end
                else
                begin
                    gap_cnt <= gap_cnt + {{(PW-1){1'b0}}, 1'b1};
                    if (ever_marker && gap_cnt >= marker_period_setting)
                        spacing_err <= 1'b1;
                end
            end
        end
    end

    // ==================================================================
    // Level status, all low under reset
    assign block_lock   = (state != ST_HUNT);
    assign marker_found = (state == ST_MARKED);
    assign word_synced  = (state == ST_MARKED);
    assign sync_err     = !word_synced && !rst;

    // ==================================================================
    // Checks
    synced_needs_lock_a: assert property (
        @(posedge core_clk) disable iff (rst)
        word_synced |-> block_lock)
        else $error("word sync without block lock");

    sync_err_excl_a: assert property (
        @(posedge core_clk) disable iff (rst)
        sync_err != word_synced)
        else $error("sync error and sync both set");

    strobe_follows_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (clk_en && word_valid) |=> err_count_valid)
        else $error("valid strobe missing");

    count_on_err_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (clk_en && word_valid && sh_error) |=> err_count == 3'h1)
        else $error("error count wrong");

    map_capture_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (clk_en && word_valid && marker_seen && state != ST_HUNT)
            |=> lane_map == $past(phys_lane))
        else $error("lane map not captured");

    spacing_flag_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (clk_en && word_valid && marker_seen && ever_marker
            && state != ST_HUNT && !gap_ok) |=> spacing_err)
        else $error("spacing error not raised");

    marker_found_a: assert property (
        @(posedge core_clk) disable iff (rst)
        marker_found |-> ever_marker)
        else $error("marker found without marker");

    hunt_clear_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (clk_en && state == ST_LOCKED && lost_lock) |=> !block_lock)
        else $error("lock kept after loss");
endmodule
`default_nettype wire

// ### rtl/lane_sync_status.sv
// Four-lane receive PCS sync and marker status
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Each lane drives a count of sync header errors, valid with its strobe.
// - Each lane has a one-bit strobe that marks its count usable that cycle.
// - A lane's bit is high while its marker is found and lane de-multiplexed.
// - Each lane presents two bits naming the physical lane that carries it.
// - A lane map is valid only while that lane's word sync bit is high.
// - A lane's bit is high only after word sync and a received marker.
// - A lane's bit is high if header errors broke sync or no marker came.
// - Spacing error is high while markers lack exactly period words between them.
// - One bit per lane is high while that lane holds 64b/66b block lock.
module lane_sync_status
    import lane_sync_pkg::*;
#(
    parameter int lane_count_param = LANES,
    parameter int PW               = PERIOD_W
)
(
    // Clock, reset, enable
    input  wire logic                               core_clk,
    input  wire logic                               rst,
    input  wire logic                               clk_en,
    // Transceiver lane indications, one bit or field per lane
    input  wire logic [lane_count_param-1:0]        lane_word_valid,
    input  wire logic [lane_count_param-1:0]        lane_sh_error,
    input  wire logic [lane_count_param-1:0]        lane_marker_seen,
    input  wire logic [lane_count_param*MAP_W-1:0]  lane_phys_id,
    // Configuration
    input  wire logic [PW-1:0]                      marker_period_setting,
    // Per-lane error counts and strobes
    output logic [lane_count_param*ERR_CNT_W-1:0]   framing_err_count,
    output logic [lane_count_param-1:0]             framing_err_valid,
    // Level status
    output logic [lane_count_param-1:0]             block_lock_bits,
    output logic [lane_count_param-1:0]             lane_marker_found,
    output logic [lane_count_param*MAP_W-1:0]       physical_lane_map,
    output logic [lane_count_param-1:0]             lane_word_sync_bits,
    output logic [lane_count_param-1:0]             lane_sync_error,
    output logic [lane_count_param-1:0]             lane_marker_spacing_error
);
    // Inputs arrive from the transceiver side of the chip, so each is
    // passed through two flops before the lane logic looks at it.
    localparam int IW = 3 + MAP_W;

    genvar g;
    generate
        for (g = 0; g < lane_count_param; g++)
        begin : lane
            logic [IW-1:0] meta;
            logic [IW-1:0] sync;

            always_ff @(posedge core_clk or posedge rst)
            begin
                if (rst)
                begin
                    meta <= '0;
                    sync <= '0;
                end
                else if (clk_en)
                begin
                    meta <= {lane_word_valid[g], lane_sh_error[g],
                             lane_marker_seen[g],
                             lane_phys_id[g*MAP_W +: MAP_W]};
                    sync <= meta;
                end
            end

            lane_sync_unit #(
                .PW (PW)
            ) u_lane (
                .core_clk              (core_clk),
                .rst                   (rst),
                .clk_en                (clk_en),
                .word_valid            (sync[IW-1]),
                .sh_error              (sync[IW-2]),
                .marker_seen           (sync[IW-3]),
                .phys_lane             (sync[MAP_W-1:0]),
                .marker_period_setting (marker_period_setting),
                .err_count       (framing_err_count[g*ERR_CNT_W +: ERR_CNT_W]),
                .err_count_valid (framing_err_valid[g]),
                .block_lock            (block_lock_bits[g]),
                .marker_found          (lane_marker_found[g]),
                .word_synced           (lane_word_sync_bits[g]),
                .sync_err              (lane_sync_error[g]),
                .spacing_err           (lane_marker_spacing_error[g]),
                .lane_map        (physical_lane_map[g*MAP_W +: MAP_W])
            );
        end
    endgenerate

    // ==================================================================
    // Top-level checks
    reset_low_a: assert property (
        @(posedge core_clk)
        rst |-> (block_lock_bits == '0 && lane_word_sync_bits == '0
                 && lane_marker_spacing_error == '0))
        else $error("status high during reset");

    found_vs_sync_a: assert property (
        @(posedge core_clk) disable iff (rst)
        lane_marker_found == lane_word_sync_bits)
        else $error("marker found and sync disagree");

    // ==================================================================
    // Strobe latency through the input synchroniser, lane 0
    sequence word_taken_s;
        clk_en && lane_word_valid[0];
    endsequence

    sequence pipe_run_s;
        clk_en ##1 clk_en;
    endsequence

    strobe_latency_a: assert property (
        @(posedge core_clk) disable iff (rst)
        word_taken_s ##1 pipe_run_s |=> framing_err_valid[0])
        else $error("strobe latency wrong");
endmodule
`default_nettype wire

// ### bench/lane_source_model.sv
// Transceiver lane source and statistics accumulator model
`timescale 1ns/1ps
`default_nettype none
module lane_source_model
    import lane_sync_pkg::*;
#(
    parameter logic [7:0] PHYS = 8'h1B
)
(
    // Clock and statistics clear
    input  wire logic                                     core_clk,
    input  wire logic                                     stats_clear,
    // Lane drive
    output logic [lane_sync_pkg::LANES-1:0]               word_valid,
    output logic [lane_sync_pkg::LANES-1:0]               sh_error,
    output logic [lane_sync_pkg::LANES-1:0]               marker_seen,
    output logic [lane_sync_pkg::LANES*MAP_W-1:0]         phys_id,
    // Statistics side
    input  wire logic [lane_sync_pkg::LANES*ERR_CNT_W-1:0] err_count,
    input  wire logic [lane_sync_pkg::LANES-1:0]          err_valid,
    output logic [63:0]                                   err_total
);
    import lane_sync_pkg::*;

    initial
    begin
        word_valid  = 4'h0;
        sh_error    = 4'h0;
        marker_seen = 4'h0;
        phys_id     = PHYS;
    end

    // Unqualified bits toggle so that stale values are never trusted
    task automatic send(input logic [3:0] vld, input logic [3:0] sh,
                        input logic [3:0] mk);
        @(negedge core_clk);
        word_valid  = vld;
        sh_error    = (sh & vld) | (~sh_error & ~vld);
        marker_seen = (mk & vld) | (~marker_seen & ~vld);
    endtask

    // Sampled only on the strobe, since the count may change any cycle
    always_ff @(posedge core_clk)
    begin
        for (int g = 0; g < LANES; g++)
        begin
            if (stats_clear)
                err_total[g*16 +: 16] <= 16'h0000;
            else if (err_valid[g])
                err_total[g*16 +: 16] <= err_total[g*16 +: 16]
                    + 16'(err_count[g*ERR_CNT_W +: ERR_CNT_W]);
        end
    end
endmodule
`default_nettype wire

// ### bench/pcs_lane_sync_status_tb.sv
// Self-checking testbench for the lane sync status block
`timescale 1ns/1ps
`default_nettype none
module pcs_lane_sync_status_tb;
    import lane_sync_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst = 1'b0;
    logic        clk_en = 1'b1;
    logic        stats_clear = 1'b0;
    logic [15:0] period = 16'h0004;
    logic [3:0]  vld, sh, mk, fv, lock, found, sync, serr, sperr;
    logic [7:0]  pid, map;
    logic [11:0] cnt;
    logic [63:0] tot;
    int          errors = 0;
    int          tests_run = 0;

    always #12.5 core_clk = ~core_clk;

    lane_source_model u_src (.core_clk(core_clk), .stats_clear(stats_clear),
        .word_valid(vld), .sh_error(sh), .marker_seen(mk), .phys_id(pid),
        .err_count(cnt), .err_valid(fv), .err_total(tot));

    lane_sync_status u_dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
        .lane_word_valid(vld), .lane_sh_error(sh), .lane_marker_seen(mk),
        .lane_phys_id(pid), .marker_period_setting(period),
        .framing_err_count(cnt), .framing_err_valid(fv),
        .block_lock_bits(lock), .lane_marker_found(found),
        .physical_lane_map(map), .lane_word_sync_bits(sync),
        .lane_sync_error(serr), .lane_marker_spacing_error(sperr));

    // ==================================================================
    // Shared helpers
    task automatic wrap_up();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic words(input int n, input logic [3:0] bad);
        repeat (n) u_src.send(4'hF, bad, 4'h0);
    endtask

    // Pipeline is three enabled edges deep; idle words let it drain
    task automatic settle();
        repeat (6) u_src.send(4'h0, 4'h0, 4'h0);
    endtask

    task automatic gap(input int n);
        words(n, 4'h0);
        u_src.send(4'hF, 4'h0, 4'hF);
    endtask

    task automatic clear_stats();
        @(negedge core_clk) stats_clear = 1'b1;
        @(negedge core_clk) stats_clear = 1'b0;
    endtask

    // ==================================================================
    // Scenarios
    task automatic test_reset_low();
        chk({fv, lock, found, sync, serr, sperr}, 32'h0);
        chk({cnt, map}, 32'h0);
    endtask

    task automatic test_count();
        int i;
        clear_stats();
        u_src.send(4'hF, 4'h1, 4'h0);
        for (i = 0; i < 8 && fv !== 4'hF; i++)
            u_src.send(4'h0, 4'h0, 4'h0);
        chk(fv, 4'hF);
        chk(cnt, 12'h001);
        u_src.send(4'h0, 4'h0, 4'h0);
        chk(fv, 4'h0);
        chk(serr, 4'hF);
    endtask

    task automatic test_lock();
        words(128, 4'h0);
        settle();
        chk(lock, 4'hF);
        chk(sync, 4'h0);
        chk(serr, 4'hF);
        u_src.send(4'hF, 4'h0, 4'hF);
        settle();
        chk(found, 4'hF);
        chk(sync, 4'hF);
        chk(serr, 4'h0);
        chk(map, 8'h1B);
    endtask

    task automatic test_spacing();
        gap(4);
        gap(4);
        settle();
        chk(sperr, 4'h0);
        gap(3);
        settle();
        chk(sperr, 4'hF);
        gap(4);
        settle();
        chk(sperr, 4'h0);
    endtask

    task automatic test_loss();
        clear_stats();
        words(128, 4'h4);
        settle();
        chk(tot[47:32], 16'h0080);
        chk(tot[15:0], 16'h0000);
        chk(lock, 4'hB);
        chk(sync, 4'hB);
        chk(serr, 4'h4);
        chk(map[5:0], 6'h1B);
    endtask

    // Low enable must freeze the input flops and the lane state
    task automatic test_freeze();
        @(negedge core_clk) clk_en = 1'b0;
        u_src.send(4'hF, 4'hF, 4'hF);
        settle();
        chk(fv, 4'h0);
        chk(lock, 4'hB);
        @(negedge core_clk) clk_en = 1'b1;
        settle();
        chk(fv, 4'h0);
        chk(sync, 4'hB);
    endtask

    initial
    begin
        // A real rising edge, so the asynchronous reset branches fire
        #1 rst = 1'b1;
        repeat (3) @(negedge core_clk);
        test_reset_low();
        rst = 1'b0;
        test_count();
        test_lock();
        test_spacing();
        test_loss();
        test_freeze();
        @(negedge core_clk) rst = 1'b1;
        @(negedge core_clk);
        test_reset_low();
        wrap_up();
    end

    initial
    begin
        #100000;
        errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
